// ### src/pwt_timer.sv
`timescale 1ns/10ps
// Overview of operation
// - Mode 110 counts when enable set
// - Edge captures count, clears counter, interrupts
// - Wrap after FFFFH raises overflow irq, flag
// - Flag cleared by bit clear or by writing 0 to bit 0
// - Overflow set beats coincident clear
// - Channel 1 external clock on event pin
// - Pulse width mode drives no waveform
// - Mode 111: reg0 cycle, regs1-3 duty
// - Compares writable live; enable off stops
// - Output 0 toggles at top and underflow
// - Triangular mode has no capture
// - Mode 111 output waveforms on four pins
// - Level zero: disabled or stopped drives low
// - Level zero, enabled: high once counting
// - Level one: inverse idle and start levels
module pwt_timer
   import pwt_pkg::*;
#(
   parameter int CHANNEL = 0
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Control
   input  wire logic [2:0]  timerModeField,
   input  wire logic        countEnableBit,
   input  wire logic        extClockSelect,
   input  wire logic [1:0]  extClockEdge,
   input  wire logic [7:0]  edgeSelectReg,
   input  wire logic [3:0]  outputLevelBit,
   input  wire logic [3:0]  outputEnableBit,
   // Compare register writes
   input  wire logic [3:0]  compareWrite,
   input  wire logic [15:0] compareWriteData,
   // Overflow flag clear
   input  wire logic        overflowBitClear,
   input  wire logic        optionRegZeroWrite,
   input  wire logic [7:0]  optionRegZeroData,
   // External pins
   input  wire logic [3:0]  captureTriggerInput,
   input  wire logic        ch1EventClockInput,
   output logic      [3:0]  timerOutputPin,
   // Status
   output logic      [15:0] counterReadBuffer,
   output logic      [15:0] captureCompareReg [4],
   output logic             overflowFlag,
   output logic      [3:0]  captureMatchIrq,
   output logic             counterOverflowIrq
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge detection
   logic [3:0] capSync1, capSync2, capPrev;
   logic       evtSync1, evtSync2, evtPrev;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         {evtSync1, capSync1} <= 5'h00;
         {evtSync2, capSync2} <= 5'h00;
         {evtPrev, capPrev}   <= 5'h00;
      end else begin
         {evtSync1, capSync1} <= {ch1EventClockInput, captureTriggerInput};
         {evtSync2, capSync2} <= {evtSync1, capSync1};
         {evtPrev, capPrev}   <= {evtSync2, capSync2};
      end
   end

   function automatic logic edgeHit(input logic [1:0] sel, input logic cur, input logic prv);
      case (sel)
         EDGE_RISE: edgeHit = cur & ~prv;
         EDGE_FALL: edgeHit = ~cur & prv;
         EDGE_BOTH: edgeHit = cur ^ prv;
         default:   edgeHit = 1'b0;
      endcase
   endfunction : edgeHit

   logic [3:0] capEdge;
   logic       extTick;
   logic       countTick;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         capEdge[i] = edgeHit(edgeSelectReg[2*i +: 2], capSync2[i], capPrev[i]);
      end
      // Channel 0 shares input 0 with the external clock; channel 1 has its own pin
      if (CHANNEL == 0) begin
         extTick = edgeHit(extClockEdge, capSync2[0], capPrev[0]);
      end else begin
         extTick = edgeHit(extClockEdge, evtSync2, evtPrev);
      end
      countTick = extClockSelect ? extTick : 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counter, captures, compares, overflow, outputs
   logic        isPulse, isTri;
   logic [15:0] counter, next_counter;
   logic [15:0] ccr [4], next_ccr [4];
   logic        ovf, next_ovf;
   pwt_dir_e    dir, next_dir;
   logic [3:0]  wave, next_wave;
   logic [3:0]  ccIrq, next_ccIrq;
   logic        ovIrq, next_ovIrq;
   logic        running, anyCap, swClear;

   assign isPulse = (timerModeField == MODE_PULSE_WIDTH);
   assign isTri   = (timerModeField == MODE_TRI_PWM);
   assign running = countEnableBit;
   assign swClear = overflowBitClear |
                    (optionRegZeroWrite & ~optionRegZeroData[OVF_FLAG_BIT]);

   always_comb begin
      next_counter = counter;
      next_ovf     = ovf;
      next_dir     = dir;
      next_wave    = wave;
      next_ccIrq   = 4'h0;
      next_ovIrq   = 1'b0;
      anyCap       = 1'b0;
      for (int i = 0; i < 4; i++) begin
         next_ccr[i] = ccr[i];
      end
      if (swClear) begin
         next_ovf = 1'b0;
      end
      if (!running) begin
         // Stopping resets counter and waveforms, as with enable cleared
         next_counter = CNT_ZERO;
         next_dir     = PWT_DIR_UP;
         next_wave    = 4'h0;
      end else if (isPulse) begin
         for (int i = 0; i < 4; i++) begin
            if (capEdge[i]) begin
               next_ccr[i]   = counter;
               next_ccIrq[i] = 1'b1;
               anyCap        = 1'b1;
            end
         end
         if (anyCap) begin
            next_counter = CNT_ZERO;
         end else if (countTick) begin
            next_counter = counter + 16'h0001;
            if (counter == CNT_MAX) begin
               next_ovIrq = 1'b1;
               next_ovf   = 1'b1;
            end
         end
      end else if (isTri && countTick) begin
         if (dir == PWT_DIR_UP) begin
            if (counter >= ccr[0]) begin
               next_dir      = PWT_DIR_DOWN;
               next_counter  = counter - 16'h0001;
               next_ccIrq[0] = 1'b1;
               next_wave[0]  = ~wave[0];
            end else begin
               next_counter = counter + 16'h0001;
            end
         end else if (counter == CNT_ZERO) begin
            next_dir     = PWT_DIR_UP;
            next_counter = counter + 16'h0001;
            next_ovIrq   = 1'b1;
            next_wave[0] = ~wave[0];
         end else begin
            next_counter = counter - 16'h0001;
         end
         for (int k = 1; k < 4; k++) begin
            if (counter == ccr[k]) begin
               next_ccIrq[k] = 1'b1;
               next_wave[k]  = (dir == PWT_DIR_UP);
            end
         end
      end
      // Compare values are taken live; capture never occurs in triangular mode
      if (!isPulse) begin
         for (int i = 0; i < 4; i++) begin
            if (compareWrite[i]) begin
               next_ccr[i] = compareWriteData;
            end
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         counter <= CNT_ZERO;
         ovf     <= 1'b0;
         dir     <= PWT_DIR_UP;
         wave    <= 4'h0;
         ccIrq   <= 4'h0;
         ovIrq   <= 1'b0;
         for (int i = 0; i < 4; i++) begin
            ccr[i] <= CCR_RESET;
         end
      end else begin
         counter <= next_counter;
         ovf     <= next_ovf;
         dir     <= next_dir;
         wave    <= next_wave;
         ccIrq   <= next_ccIrq;
         ovIrq   <= next_ovIrq;
         for (int i = 0; i < 4; i++) begin
            ccr[i] <= next_ccr[i];
         end
      end
   end

   // Pin level: idle level from level bit, active waveform inverted by it
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (!outputEnableBit[i] || !running || isPulse) begin
            timerOutputPin[i] = outputLevelBit[i];
         end else begin
            timerOutputPin[i] = outputLevelBit[i] ^ ~wave[i];
         end
      end
   end

   assign counterReadBuffer  = counter;
   assign captureCompareReg  = ccr;
   assign overflowFlag       = ovf;
   assign captureMatchIrq    = ccIrq;
   assign counterOverflowIrq = ovIrq;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   property p_capture_clears;
      @(posedge clk) disable iff (sys_rst)
      (running && isPulse && capEdge[1]) |=> (counter == CNT_ZERO && ccIrq[1]);
   endproperty
   a_capture_clears: assert property (p_capture_clears) else $error("capture no clear");

   property p_capture_value;
      @(posedge clk) disable iff (sys_rst)
      (running && isPulse && capEdge[0]) |=> (ccr[0] == $past(counter));
   endproperty
   a_capture_value: assert property (p_capture_value) else $error("capture value wrong");

   property p_overflow;
      @(posedge clk) disable iff (sys_rst)
      (running && isPulse && !anyCap && countTick && counter == CNT_MAX)
         |=> (ovIrq && ovf && counter == CNT_ZERO);
   endproperty
   a_overflow: assert property (p_overflow) else $error("overflow missed");

   property p_set_wins;
      @(posedge clk) disable iff (sys_rst)
      (swClear && running && isPulse && !anyCap && countTick && counter == CNT_MAX) |=> ovf;
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("clear beat overflow");

   property p_clear;
      @(posedge clk) disable iff (sys_rst)
      (swClear && !next_ovIrq) |=> !ovf;
   endproperty
   a_clear: assert property (p_clear) else $error("flag not cleared");

   property p_pulse_no_wave;
      @(posedge clk) disable iff (sys_rst)
      isPulse |-> (timerOutputPin == outputLevelBit);
   endproperty
   a_pulse_no_wave: assert property (p_pulse_no_wave) else $error("wave in pulse mode");

   property p_stopped_level;
      @(posedge clk) disable iff (sys_rst)
      !running |-> (timerOutputPin == outputLevelBit);
   endproperty
   a_stopped_level: assert property (p_stopped_level) else $error("idle level wrong");

   property p_hold;
      @(posedge clk) disable iff (sys_rst)
      (isPulse && !capEdge[2] && !compareWrite[2]) |=> $stable(ccr[2]);
   endproperty
   a_hold: assert property (p_hold) else $error("capture changed");

   property p_tri_toggle;
      @(posedge clk) disable iff (sys_rst)
      (running && isTri && countTick && dir == PWT_DIR_DOWN && counter == CNT_ZERO)
         |=> (wave[0] != $past(wave[0]));
   endproperty
   a_tri_toggle: assert property (p_tri_toggle) else $error("no underflow toggle");

   property p_stop;
      @(posedge clk) disable iff (sys_rst)
      !running |=> (counter == CNT_ZERO);
   endproperty
   a_stop: assert property (p_stop) else $error("timer not stopped");

endmodule : pwt_timer

// ### include/pwt_pkg.sv
package pwt_pkg;
   localparam logic [2:0]  MODE_PULSE_WIDTH = 3'h6;
   localparam logic [2:0]  MODE_TRI_PWM     = 3'h7;
   localparam logic [15:0] CNT_ZERO         = 16'h0000;
   localparam logic [15:0] CNT_MAX          = 16'hffff;
   localparam logic [15:0] CCR_RESET        = 16'h0000;
   localparam int          SYNC_STAGES      = 2;
   localparam logic [1:0]  EDGE_NONE        = 2'h0;
   localparam logic [1:0]  EDGE_RISE        = 2'h1;
   localparam logic [1:0]  EDGE_FALL        = 2'h2;
   localparam logic [1:0]  EDGE_BOTH        = 2'h3;
   localparam int          OVF_FLAG_BIT     = 0;

   typedef enum logic [0:0] {
      PWT_DIR_UP   = 1'b0,
      PWT_DIR_DOWN = 1'b1
   } pwt_dir_e;
endpackage : pwt_pkg

// ### bench/pwt_pulse_src.sv
`timescale 1ns/10ps
module pwt_pulse_src (
   // Clock
   input  wire logic       clk,
   // Pins toward the timer
   output logic      [3:0] capturePin,
   output logic            eventPin
);
   initial begin
      capturePin = 4'h0;
      eventPin   = 1'b0;
   end
   // Free-running event source; only a channel 1 timer would count it
   always @(posedge clk) begin
      eventPin <= ~eventPin;
   end
   // One level change just after an edge, as a clean external source would
   task automatic flip(input int m);
      @(posedge clk);
      capturePin[m] <= ~capturePin[m];
   endtask : flip
endmodule : pwt_pulse_src

// ### bench/pulse_width_tri_pwm_timer_tb.sv
`timescale 1ns/10ps
module pulse_width_tri_pwm_timer_tb;
   import pwt_pkg::*;
   logic        clk = 1'b0;
   logic        sysRst = 1'b1;
   logic [2:0]  mode = 3'h0;
   logic        ce = 1'b0;
   logic [7:0]  eSel = 8'h00;
   logic [3:0]  lvl = 4'h0, oe = 4'h0, cw = 4'h0, kn = 4'h0, p, pin, irq, cap;
   logic [15:0] cwD = 16'h0000, cnt, ccr [4], ex [4], c0;
   logic [7:0]  optD = 8'h00;
   logic        bClr = 1'b0, optW = 1'b0, ev, ovf, ovIrq, v, extSel = 1'b0;
   logic [1:0]  extEdge = 2'h0;
   // Software overflow copies, one per capture register
   int          swOvf [4];
   integer      seed = 32'h13b1bafb;
   int          n_mismatch = 0, checks_done = 0, cyc = 0, last = 0, tg = 0, code;

   always #10 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   pwt_pulse_src src (.clk(clk), .capturePin(cap), .eventPin(ev));
   pwt_timer #(.CHANNEL(0)) dut (
      .clk(clk), .sys_rst(sysRst), .timerModeField(mode), .countEnableBit(ce),
      .extClockSelect(extSel), .extClockEdge(extEdge), .edgeSelectReg(eSel),
      .outputLevelBit(lvl), .outputEnableBit(oe), .compareWrite(cw),
      .compareWriteData(cwD), .overflowBitClear(bClr), .optionRegZeroWrite(optW),
      .optionRegZeroData(optD), .captureTriggerInput(cap), .ch1EventClockInput(ev),
      .timerOutputPin(pin), .counterReadBuffer(cnt), .captureCompareReg(ccr),
      .overflowFlag(ovf), .captureMatchIrq(irq), .counterOverflowIrq(ovIrq));

   task automatic chk(input logic [15:0] s, input logic [15:0] e, input string w);
      checks_done++;
      if (s !== e) begin
         n_mismatch++;
         $display("[FAIL] %0t %s: %h not %h", $time, w, s, e);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   // Only registers whose expected value is known are compared
   task automatic ccrAll();
      for (int i = 0; i < 4; i++)
         if (kn[i]) chk(ccr[i], ex[i], "capture reg");
   endtask : ccrAll

   function automatic logic triPin(input logic [15:0] c, input logic [15:0] d, input logic l);
      return l ^ (c < d);
   endfunction : triPin

   // Compare match pulses follow the count seen one edge earlier
   function automatic logic [3:0] triIrq(input logic [15:0] c);
      for (int k = 0; k < 4; k++)
         triIrq[k] = (c == ex[k]);
   endfunction : triIrq

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : summarize

   // Longest path is one full counter wrap
   initial begin
      #(90000 * 20);
      n_mismatch++;
      summarize();
   end

   initial begin
      lvl = 4'($random(seed));
      tick(8);
      chk(pin, lvl, "reset pins");
      chk(ovf, 0, "reset flag");
      @(posedge clk);
      sysRst <= 1'b0;
      mode <= MODE_PULSE_WIDTH;
      ce <= 1'b1;
      oe <= 4'hf;
      tick(4);
      for (int m = 0; m < 4; m++) begin
         code = {$random(seed)} % 3 + 1;
         @(posedge clk);
         eSel <= 8'(code << (2 * m));
         tick(4);
         for (int t = 0; t < 6; t++) begin
            v = cap[m] ? code[1] : code[0];
            src.flip(m);
            tick(3);
            chk(irq[m], v, "capture irq");
            if (v) begin
               chk(cnt, CNT_ZERO, "cleared");
               if (last > 0) begin
                  ex[m] = 16'(cyc - last - 1);
                  kn[m] = 1'b1;
               end
               last = cyc;
            end
            ccrAll();
            chk(pin, lvl, "no wave");
            tick({$random(seed)} % 20);
         end
      end
      @(posedge clk);
      cw <= 4'hf;
      cwD <= 16'h1234;
      @(posedge clk);
      cw <= 4'h0;
      tick(1);
      ccrAll();
      $display("capture test done");
      // Clear timed to land on the wrap edge itself
      for (int i = 0; i < 70000 && cnt !== 16'hfffe; i++)
         tick(1);
      @(posedge clk);
      bClr <= 1'b1;
      @(posedge clk);
      bClr <= 1'b0;
      #1;
      chk(ovIrq, 1, "ovf irq");
      chk(cnt, CNT_ZERO, "wrap");
      chk(ovf, 1, "clear lost");
      for (int i = 0; i < 4; i++) swOvf[i]++;
      @(posedge clk);
      optW <= 1'b1;
      optD <= 8'h01;
      @(posedge clk);
      optW <= 1'b0;
      tick(1);
      chk(ovIrq, 0, "irq pulse");
      chk(ovf, 1, "bit0 set");
      @(posedge clk);
      bClr <= 1'b1;
      @(posedge clk);
      bClr <= 1'b0;
      tick(1);
      chk(ovf, 0, "bit clear");
      // Width across one wrap: overflow count plus the captured low part
      @(posedge clk);
      eSel <= 8'h0c;
      tick(4);
      src.flip(1);
      tick(3);
      chk(ccr[1], 16'(cyc - last - 1), "width low");
      chk(16'(swOvf[1]), 16'((cyc - last - 1) >>> 16), "overflows");
      swOvf[1] = 0;
      $display("overflow test done");
      // External clock on input 0 while input 1 measures
      @(posedge clk);
      extSel <= 1'b1;
      extEdge <= EDGE_RISE;
      tick(4);
      src.flip(1);
      tick(4);
      code = {$random(seed)} % 8 + 1;
      repeat (2 * code) src.flip(0);
      tick(4);
      src.flip(1);
      tick(3);
      chk(ccr[1], 16'(code), "event count");
      $display("external clock test done");
      @(posedge clk);
      ce <= 1'b0;
      extSel <= 1'b0;
      mode <= MODE_TRI_PWM;
      lvl <= 4'($random(seed));
      oe <= 4'($random(seed));
      tick(2);
      chk(cnt, CNT_ZERO, "stopped");
      chk(pin, lvl, "idle pins");
      for (int k = 0; k < 4; k++) begin
         ex[k] = (k > 0) ? 16'({$random(seed)} % 36 + 2) : 16'd40;
         kn[k] = 1'b1;
         @(posedge clk);
         cw <= 4'(1 << k);
         cwD <= ex[k];
      end
      @(posedge clk);
      cw <= 4'h0;
      oe <= 4'hf;
      tick(1);
      ccrAll();
      @(posedge clk);
      ce <= 1'b1;
      tick(1);
      p = pin;
      c0 = cnt;
      for (int i = 0; i < 400; i++) begin
         tick(1);
         chk(cnt > ex[0], 0, "above cycle");
         chk(irq, triIrq(c0), "compare irq");
         chk(ovIrq, c0 == CNT_ZERO, "underflow irq");
         c0 = cnt;
         tg += int'(pin[0] !== p[0]);
         p = pin;
         for (int k = 1; k < 4; k++)
            if (cnt + 1 < ex[k] || cnt > ex[k] + 1)
               chk(pin[k], triPin(cnt, ex[k], lvl[k]), "duty");
      end
      chk(tg inside {[9:11]}, 1, "pin0 toggles");
      @(posedge clk);
      cw <= 4'h2;
      cwD <= 16'h0005;
      ex[1] = 16'h0005;
      @(posedge clk);
      cw <= 4'h0;
      eSel <= 8'hff;
      tick(4);
      chk(ccr[1], ex[1], "live write");
      src.flip(2);
      tick(2);
      c0 = cnt;
      tick(1);
      chk(irq, triIrq(c0), "no capture");
      ccrAll();
      @(posedge clk);
      ce <= 1'b0;
      tick(2);
      chk(cnt, CNT_ZERO, "stop");
      chk(pin, lvl, "stop pins");
      $display("triangular test done");
      summarize();
   end
endmodule : pulse_width_tri_pwm_timer_tb
